// ---- logic/gpib_bus_command_decoder.sv ----
// device-side decoder for uniline and multiline bus commands
`default_nettype none
module gpib_bus_command_decoder
	import gpib_cmd_pkg::*;
(
	input wire logic mclk, // system clock, 25 MHz
	input wire logic reset, // synchronous reset, high
	input wire logic atn_n, // attention pin, low true
	input wire logic ren_n, // remote enable pin, low true
	input wire logic ifc_n, // interface clear pin, low true
	input wire logic eoi_i_n, // end or identify pin level, low true
	input wire logic rx_stb, // one byte accepted by the handshake logic
	input wire logic [7:0] rx_byte, // accepted byte, high true
	input wire cfg_t cfg, // address and option straps
	input wire logic service_req, // instrument wants service
	output logic srq_o, // srq pin drive value
	output logic srq_oe_n, // srq pin enable, low while driving
	output logic eoi_o, // eoi pin drive value
	output logic eoi_oe_n, // eoi pin enable, low while driving
	output iface_t state, // remote, lockout, listen, talk, poll
	output logic panel_off, // front panel controls disabled
	output logic local_key_en, // local-return key usable
	output logic dev_clear, // pulse: restore power-up defaults
	output logic trigger, // pulse: start trigger action
	output byte_t data_out, // data byte for the command parser
	output logic data_valid, // pulse: data_out holds a new byte
	input wire byte_t tx_src, // instrument byte to talk
	input wire logic tx_valid, // instrument offers a byte
	output logic tx_ready, // talker stage takes the byte
	output byte_t talk_byte, // byte toward the handshake logic
	output logic talk_valid, // talk_byte is held
	input wire logic talk_ready // handshake logic took talk_byte
);
	typedef struct packed {
		iface_t ifs;
		logic ren_d;
		logic clr;
		logic trig;
		byte_t rx;
		logic rx_valid;
	} dec_state_t;
	dec_state_t s_ff;
	dec_state_t nxt_s;
	uniline_t lines;
	logic [6:0] cb;
	logic cmd_stb;
	logic data_stb;
	byte_t poll_byte;
	byte_t talk_src;
	logic talk_src_valid;
	logic talk_src_ready;

	// address byte from the primary address and a group base
	function automatic logic [6:0] addr_of(input logic [6:0] base, input logic [4:0] pa);
		addr_of = base | {2'h0, pa};
	endfunction

	// command bytes are judged on seven bits; bit 8 of the bus is ignored
	function automatic logic is_cmd(input logic [7:0] b, input logic [6:0] code);
		is_cmd = (b[6:0] == code);
	endfunction

	// pins come from the bus, so they pass two flip-flops first
	uniline_sync u_sync (
		.mclk(mclk),
		.reset(reset),
		.pins_n({atn_n, ren_n, ifc_n, eoi_i_n}),
		.lines(lines)
	);

	assign cb = rx_byte[6:0];
	assign cmd_stb = rx_stb && lines.atn;
	assign data_stb = rx_stb && !lines.atn;

	// interface state update; ifc is applied last so it overrides commands
	always_comb begin
		nxt_s = s_ff;
		nxt_s.clr = 1'b0;
		nxt_s.trig = 1'b0;
		nxt_s.rx_valid = 1'b0;
		nxt_s.ren_d = lines.ren;
		// leaving remote when ren drops also ends any lockout
		if (lines.ren && !s_ff.ren_d) begin
			nxt_s.ifs.remote = 1'b1;
		end
		if (!lines.ren) begin
			nxt_s.ifs.remote = 1'b0;
			nxt_s.ifs.lockout = 1'b0;
		end
		if (cmd_stb) begin
			case (cb[6:5])
				GRP_CMD: begin
					case (cb)
						// universal group acts with no addressing
						CMD_LLO: begin
							if (lines.ren) begin
								nxt_s.ifs.lockout = 1'b1;
							end
						end
						CMD_DCL: begin
							nxt_s.clr = 1'b1;
							nxt_s.ifs.spoll = 1'b0;
						end
						CMD_SPE: nxt_s.ifs.spoll = 1'b1;
						CMD_SPD: nxt_s.ifs.spoll = 1'b0;
						// addressed group needs our listen address first; GET also acts unaddressed when get_unaddressed is set
						CMD_SDC: begin
							if (s_ff.ifs.listen) begin
								nxt_s.clr = 1'b1;
								nxt_s.ifs.spoll = 1'b0;
							end
						end
						CMD_GTL: begin
							if (s_ff.ifs.listen) begin
								nxt_s.ifs.remote = 1'b0;
								if (cfg.gtl_unlocks) begin
									nxt_s.ifs.lockout = 1'b0;
								end
							end
						end
						CMD_GET: begin
							if (s_ff.ifs.listen || cfg.get_unaddressed) begin
								nxt_s.trig = 1'b1;
							end
						end
						default: begin
							// other command codes are not implemented
						end
					endcase
				end
				GRP_LISTEN: begin
					if (cb == CMD_UNL) begin
						nxt_s.ifs.listen = 1'b0;
					end else if (cb == addr_of(LISTEN_BASE, cfg.primary_addr)) begin
						nxt_s.ifs.listen = 1'b1;
						if (lines.ren) begin
							nxt_s.ifs.remote = 1'b1;
						end
					end
				end
				GRP_TALK: begin
					if (cb == CMD_UNT) begin
						nxt_s.ifs.talk = 1'b0;
					end else if (cb == addr_of(TALK_BASE, cfg.primary_addr)) begin
						nxt_s.ifs.talk = 1'b1;
					end else begin
						nxt_s.ifs.talk = 1'b0;
					end
				end
				default: begin
					// secondary addresses are unused and leave all state alone
				end
			endcase
		end else if (data_stb && s_ff.ifs.listen) begin
			nxt_s.rx.data = rx_byte;
			nxt_s.rx.last = lines.eoi;
			nxt_s.rx_valid = 1'b1;
		end
		if (lines.ifc) begin
			nxt_s.ifs.listen = 1'b0;
			nxt_s.ifs.talk = 1'b0;
			nxt_s.ifs.spoll = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// poll mode replaces instrument data with a single status byte
	always_comb begin
		poll_byte.data = POLL_BASE;
		poll_byte.data[RSV_BIT] = service_req;
		poll_byte.last = 1'b1;
		if (s_ff.ifs.spoll) begin
			talk_src = poll_byte;
			talk_src_valid = 1'b1;
		end else begin
			talk_src = tx_src;
			talk_src_valid = tx_valid;
		end
	end

	talk_eoi u_talk (
		.mclk(mclk),
		.reset(reset),
		.talk_active(s_ff.ifs.talk),
		.src(talk_src),
		.src_valid(talk_src_valid),
		.src_ready(talk_src_ready),
		.out(talk_byte),
		.out_valid(talk_valid),
		.out_ready(talk_ready),
		.eoi_o(eoi_o),
		.eoi_oe_n(eoi_oe_n)
	);

	// instrument sees no ready while the poll byte owns the talker
	assign tx_ready = talk_src_ready && !s_ff.ifs.spoll;

	// srq follows the request level; the controller finds us by polling
	assign srq_o = 1'b0;
	assign srq_oe_n = !service_req;

	assign state = s_ff.ifs;
	// lockout kills even the local key; ren alone spares it
	assign panel_off = s_ff.ifs.lockout || (s_ff.ifs.remote && cfg.lock_on_ren);
	assign local_key_en = !s_ff.ifs.lockout;
	assign dev_clear = s_ff.clr;
	assign trigger = s_ff.trig;
	assign data_out = s_ff.rx;
	assign data_valid = s_ff.rx_valid;

	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (reset);

	a_atn_no_data: assert property (cmd_stb |=> !data_valid)
		else $error("command byte leaked as data");
	a_ren_remote: assert property (lines.ren && !s_ff.ren_d && !cmd_stb |=> state.remote)
		else $error("remote not entered on ren");
	a_ren_panel: assert property (lines.ren && !s_ff.ren_d && !cmd_stb && cfg.lock_on_ren
		|=> panel_off && local_key_en || state.lockout)
		else $error("panel not disabled under ren");
	a_eoi_last: assert property (data_stb && state.listen
		|=> data_valid && data_out.last == $past(lines.eoi))
		else $error("end flag lost on data byte");
	a_ifc_idle: assert property (lines.ifc |=> !state.listen && !state.talk && !state.spoll)
		else $error("ifc did not idle interface");
	a_srq_drive: assert property ($rose(service_req) |-> !srq_oe_n ##1 (srq_oe_n == !service_req))
		else $error("srq not driven");
	a_llo_lock: assert property (cmd_stb && cb == CMD_LLO && lines.ren
		|=> state.lockout && !local_key_en && panel_off)
		else $error("lockout not set");
	a_dcl_pulse: assert property (cmd_stb && cb == CMD_DCL |=> dev_clear ##1 !dev_clear)
		else $error("device clear pulse wrong");
	a_spe_enter: assert property (cmd_stb && cb == CMD_SPE && !lines.ifc |=> state.spoll)
		else $error("poll mode not entered");
	a_spd_leave: assert property (cmd_stb && cb == CMD_SPD |=> !state.spoll)
		else $error("poll mode not left");
	a_sdc_unaddr: assert property (cmd_stb && cb == CMD_SDC && !state.listen |=> !dev_clear)
		else $error("selective clear acted unaddressed");
	a_sdc_clear: assert property (cmd_stb && cb == CMD_SDC && state.listen |=> dev_clear)
		else $error("selective clear ignored");
	a_gtl_local: assert property (cmd_stb && cb == CMD_GTL && state.listen |=> !state.remote)
		else $error("go to local ignored");
	a_get_trig: assert property (cmd_stb && cb == CMD_GET && (state.listen || cfg.get_unaddressed)
		|=> trigger ##1 !trigger)
		else $error("trigger pulse wrong");
	a_own_listen: assert property (cmd_stb && cb == addr_of(LISTEN_BASE, cfg.primary_addr)
		&& cb != CMD_UNL && !lines.ifc |=> state.listen)
		else $error("own listen address missed");
	a_own_talk: assert property (cmd_stb && cb == addr_of(TALK_BASE, cfg.primary_addr)
		&& cb != CMD_UNT && !lines.ifc |=> state.talk)
		else $error("own talk address missed");
	a_second_none: assert property (cmd_stb && cb[6:5] == GRP_SECOND && !lines.ifc
		&& lines.ren == s_ff.ren_d |=> $stable(state))
		else $error("secondary byte changed state");
	a_unl_drop: assert property (cmd_stb && cb == CMD_UNL |=> !state.listen)
		else $error("unlisten ignored");
	a_unt_drop: assert property (cmd_stb && cb == CMD_UNT |=> !state.talk)
		else $error("untalk ignored");
	a_data_pass: assert property (data_stb && state.listen |=> data_valid
		&& data_out.data == $past(rx_byte))
		else $error("data byte not passed");
	a_other_talk: assert property (cmd_stb && cb[6:5] == GRP_TALK
		&& cb != addr_of(TALK_BASE, cfg.primary_addr) |=> !state.talk)
		else $error("second talker kept");

	c_poll_talk: cover property (state.spoll && state.talk && talk_valid);
	c_data_end: cover property (data_valid && data_out.last);
	c_trigger: cover property (trigger);
	c_lock_local: cover property (state.lockout ##[1:20] !state.remote);
endmodule
`default_nettype wire

// ---- logic/gpib_cmd_pkg.sv ----
// constants and carrier types for the bus command decoder
`default_nettype none
package gpib_cmd_pkg;
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3F;
	localparam logic [6:0] CMD_UNT = 7'h5F;
	localparam logic [6:0] LISTEN_BASE = 7'h20;
	localparam logic [6:0] TALK_BASE = 7'h40;
	// command group is held in byte bits 6:5
	localparam logic [1:0] GRP_CMD = 2'h0;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	localparam logic [1:0] GRP_SECOND = 2'h3;
	localparam int RSV_BIT = 6;
	localparam logic [7:0] POLL_BASE = 8'h00;
	localparam logic [3:0] SYNC_RESET = 4'hF;
	// uniline levels, positive logic after synchronising
	typedef struct packed {
		logic atn;
		logic ren;
		logic ifc;
		logic eoi;
	} uniline_t;
	typedef struct packed {
		logic [4:0] primary_addr;
		logic lock_on_ren;
		logic gtl_unlocks;
		logic get_unaddressed;
	} cfg_t;
	typedef struct packed {
		logic remote;
		logic lockout;
		logic listen;
		logic talk;
		logic spoll;
	} iface_t;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} byte_t;
endpackage
`default_nettype wire

// ---- logic/uniline_sync.sv ----
// two-stage synchroniser for the active-low uniline bus pins
`default_nettype none
module uniline_sync
	import gpib_cmd_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic reset, // synchronous reset
	input wire logic [3:0] pins_n, // atn, ren, ifc, eoi pins, low true
	output uniline_t lines // synchronised, high true
);
	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] stable;
	} sync_state_t;
	sync_state_t s_ff;
	sync_state_t nxt_s;

	// first stage is read only by the second; idle bus is all high
	always_comb begin
		nxt_s = s_ff;
		nxt_s.meta = pins_n;
		nxt_s.stable = s_ff.meta;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_ff.meta <= SYNC_RESET;
			s_ff.stable <= SYNC_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign lines = ~s_ff.stable;
endmodule
`default_nettype wire

// ---- logic/talk_eoi.sv ----
// one-byte talker output stage that drives EOI with the final byte
`default_nettype none
module talk_eoi
	import gpib_cmd_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic reset, // synchronous reset
	input wire logic talk_active, // talker-active state
	input wire byte_t src, // byte and last flag to send
	input wire logic src_valid, // source offers a byte
	output logic src_ready, // stage can take a byte
	output byte_t out, // byte toward the handshake logic
	output logic out_valid, // byte held for the handshake logic
	input wire logic out_ready, // handshake logic took the byte
	output logic eoi_o, // eoi pin drive value
	output logic eoi_oe_n // eoi pin enable, low while driving
);
	typedef struct packed {
		byte_t hold;
		logic full;
	} talk_state_t;
	talk_state_t s_ff;
	talk_state_t nxt_s;

	// a held byte is dropped if talking stops so stale data never leaves
	always_comb begin
		nxt_s = s_ff;
		if (!talk_active) begin
			nxt_s.full = 1'b0;
		end else if (src_valid && src_ready) begin
			nxt_s.hold = src;
			nxt_s.full = 1'b1;
		end else if (out_ready && s_ff.full) begin
			nxt_s.full = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign src_ready = talk_active && (!s_ff.full || out_ready);
	assign out = s_ff.hold;
	assign out_valid = s_ff.full;
	// eoi is pulled low only alongside the final byte
	assign eoi_o = 1'b0;
	assign eoi_oe_n = !(s_ff.full && s_ff.hold.last && talk_active);
endmodule
`default_nettype wire

// ---- tb/bus_ctrl_model.sv ----
// behavioural bus controller: drives the management pins, hands bytes in, takes talked bytes
`default_nettype none
module bus_ctrl_model
	import gpib_cmd_pkg::*;
(
	input wire logic mclk, // system clock
	output logic atn_n, // attention, low true
	output logic ren_n, // remote enable, low true
	output logic ifc_n, // interface clear, low true
	output logic eoi_n, // end or identify, low true
	output logic rx_stb, // byte accepted pulse
	output logic [7:0] rx_byte, // accepted byte
	input wire byte_t talk_byte, // byte from the talker
	input wire logic talk_valid, // talker holds a byte
	output logic talk_ready // byte taken
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus: every management line released to its pull-up
	initial begin
		atn_n = 1'b1;
		ren_n = 1'b1;
		ifc_n = 1'b1;
		eoi_n = 1'b1;
		rx_stb = 1'b0;
		rx_byte = 8'hA5;
		talk_ready = 1'b0;
	end
	// uniline levels, then time for the synchroniser and the state update
	task automatic lines(input logic ren, input logic ifc);
		@(negedge mclk);
		ren_n = ~ren;
		ifc_n = ~ifc;
		repeat (4) @(negedge mclk);
	endtask
	// one byte; atn settles before and stays through the byte
	task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
		@(negedge mclk);
		atn_n = ~atn;
		eoi_n = ~eoi;
		repeat (3) @(negedge mclk);
		rx_byte = b;
		rx_stb = 1'b1;
		@(negedge mclk);
		rx_stb = 1'b0;
		rx_byte = ~b; // released lines never show the stale byte
		eoi_n = 1'b1;
		// return here so the caller still sees the one-cycle answer pulses
	endtask
	// takes one talked byte after a stall of the given length
	task automatic accept(input int stall, output byte_t got);
		int n;
		n = 0;
		while (talk_valid !== 1'b1 && n < 50) begin
			@(negedge mclk);
			n++;
		end
		repeat (stall) @(negedge mclk);
		got = talk_byte;
		talk_ready = 1'b1;
		@(negedge mclk);
		talk_ready = 1'b0;
		@(negedge mclk);
	endtask
endmodule
`default_nettype wire

// ---- tb/gpib_bus_command_decoder_test.sv ----
// self-checking bench for the bus command decoder
`default_nettype none
module gpib_bus_command_decoder_test;
	import gpib_cmd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, reset, service_req, tx_valid;
	cfg_t cfg;
	byte_t tx_src, data_out, talk_byte, got;
	iface_t state;
	wire logic atn_n, ren_n, ifc_n, eoi_n, rx_stb, talk_ready, eoi_line_n;
	wire logic [7:0] rx_byte;
	logic srq_o, srq_oe_n, eoi_o, eoi_oe_n, panel_off, local_key_en;
	logic dev_clear, trigger, data_valid, tx_ready, talk_valid;
	int n_mismatch = 0;
	int checks_done = 0;
	// eoi is shared: either party may pull the line low
	assign eoi_line_n = eoi_n & (eoi_oe_n | eoi_o);
	gpib_bus_command_decoder dut_u (.mclk(mclk), .reset(reset), .atn_n(atn_n), .ren_n(ren_n),
		.ifc_n(ifc_n), .eoi_i_n(eoi_line_n), .rx_stb(rx_stb), .rx_byte(rx_byte), .cfg(cfg),
		.service_req(service_req), .srq_o(srq_o), .srq_oe_n(srq_oe_n), .eoi_o(eoi_o),
		.eoi_oe_n(eoi_oe_n), .state(state), .panel_off(panel_off),
		.local_key_en(local_key_en), .dev_clear(dev_clear), .trigger(trigger),
		.data_out(data_out), .data_valid(data_valid), .tx_src(tx_src), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .talk_byte(talk_byte), .talk_valid(talk_valid),
		.talk_ready(talk_ready));
	bus_ctrl_model ctl_u (.mclk(mclk), .atn_n(atn_n), .ren_n(ren_n), .ifc_n(ifc_n),
		.eoi_n(eoi_n), .rx_stb(rx_stb), .rx_byte(rx_byte), .talk_byte(talk_byte),
		.talk_valid(talk_valid), .talk_ready(talk_ready));
	// free-running clock
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;
	task automatic cmp_bit(input string what, input logic exp, input logic seen);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic cmp_state(input iface_t exp);
		checks_done++;
		if (state !== exp) begin
			n_mismatch++;
			$display("mismatch state expected %b seen %b", exp, state);
		end
	endtask
	task automatic cmp_byte(input string what, input byte_t exp, input byte_t seen);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// command byte with attention held true
	task automatic cmd(input logic [7:0] b);
		ctl_u.send(b, 1'b1, 1'b0);
	endtask
	// offers one instrument byte; waits for the talker stage to take it
	task automatic push(input logic [7:0] b, input logic last);
		int n;
		n = 0;
		tx_src = {b, last};
		tx_valid = 1'b1;
		while (tx_ready !== 1'b1 && n < 50) begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		tx_valid = 1'b0;
	endtask
	task automatic t_addr(input logic [4:0] pa);
		cfg.primary_addr = pa;
		cmd({3'h1, pa});
		cmp_state(5'b00100);
		cmd({3'h2, pa});
		cmp_state(5'b00110);
		cmd({3'h3, pa});
		cmp_state(5'b00110);
		cmd({3'h2, pa ^ 5'h02});
		cmp_state(5'b00100);
		cmd({3'h2, pa});
		cmd(8'h5F);
		cmp_state(5'b00100);
		cmd(8'h3F);
		cmp_state(5'b00000);
	endtask
	task automatic t_remote();
		cfg.lock_on_ren = 1'b1;
		cfg.gtl_unlocks = 1'b1;
		ctl_u.lines(1'b1, 1'b0);
		cmp_state(5'b10000);
		cmp_bit("panel_off", 1'b1, panel_off);
		cmp_bit("local_key_en", 1'b1, local_key_en);
		cmd({1'b0, CMD_LLO});
		cmp_state(5'b11000);
		cmp_bit("local_key_en", 1'b0, local_key_en);
		cmd({1'b0, CMD_GTL});
		cmp_state(5'b11000);
		cmd(8'h3E);
		cmd({1'b0, CMD_GTL});
		cmp_state(5'b00100);
		cmp_bit("panel_off", 1'b0, panel_off);
		ctl_u.lines(1'b0, 1'b0);
		cmd(8'h3F);
	endtask
	task automatic t_clear();
		cfg.get_unaddressed = 1'b0;
		cmd({1'b0, CMD_SDC});
		cmp_bit("dev_clear", 1'b0, dev_clear);
		cmd({1'b0, CMD_GET});
		cmp_bit("trigger", 1'b0, trigger);
		cmd({1'b0, CMD_DCL});
		cmp_bit("dev_clear", 1'b1, dev_clear);
		cmd(8'h3E);
		cmd({1'b0, CMD_SDC});
		cmp_bit("dev_clear", 1'b1, dev_clear);
		cmd({1'b0, CMD_GET});
		cmp_bit("trigger", 1'b1, trigger);
		cmd(8'h3F);
		cfg.get_unaddressed = 1'b1;
		cmd({1'b0, CMD_GET});
		cmp_bit("trigger", 1'b1, trigger);
	endtask
	task automatic t_data();
		cmd(8'h3E);
		ctl_u.send(8'h41, 1'b0, 1'b0);
		cmp_bit("data_valid", 1'b1, data_valid);
		cmp_byte("data_out", {8'h41, 1'b0}, data_out);
		ctl_u.send(8'h42, 1'b0, 1'b1);
		cmp_byte("data_out", {8'h42, 1'b1}, data_out);
		ctl_u.send(8'h14, 1'b0, 1'b0);
		cmp_bit("dev_clear", 1'b0, dev_clear);
		cmd(8'h41);
		cmp_bit("data_valid", 1'b0, data_valid);
		cmd(8'h3F);
		ctl_u.send(8'h43, 1'b0, 1'b0);
		cmp_bit("data_valid", 1'b0, data_valid);
	endtask
	task automatic t_talk();
		cmd(8'h5E);
		push(8'h5A, 1'b0);
		cmp_bit("eoi_oe_n", 1'b1, eoi_oe_n);
		ctl_u.accept(3, got);
		cmp_byte("talk_byte", {8'h5A, 1'b0}, got);
		push(8'hA5, 1'b1);
		cmp_bit("eoi_oe_n", 1'b0, eoi_oe_n);
		cmp_bit("eoi_o", 1'b0, eoi_o);
		ctl_u.accept(0, got);
		cmp_byte("talk_byte", {8'hA5, 1'b1}, got);
		cmp_bit("talk_valid", 1'b0, talk_valid);
		cmd(8'h5F);
	endtask
	task automatic t_poll();
		service_req = 1'b1;
		cmd({1'b0, CMD_SPE});
		cmp_state(5'b00001);
		cmp_bit("srq_oe_n", 1'b0, srq_oe_n);
		cmp_bit("srq_o", 1'b0, srq_o);
		cmd(8'h5E);
		ctl_u.accept(2, got);
		cmp_byte("status", {8'h40, 1'b1}, got);
		cmd(8'h5F);
		cmd({1'b0, CMD_SPD});
		cmp_state(5'b00000);
		service_req = 1'b0;
		cmd(8'h5E);
		push(8'h33, 1'b1);
		ctl_u.accept(1, got);
		cmp_byte("talk_byte", {8'h33, 1'b1}, got);
		cmd({1'b0, CMD_SPE});
		cmd({1'b0, CMD_DCL});
		cmp_state(5'b00010);
		cmp_bit("srq_oe_n", 1'b1, srq_oe_n);
		cmd(8'h3E);
		ctl_u.lines(1'b0, 1'b1);
		cmp_state(5'b00000);
		ctl_u.lines(1'b0, 1'b0);
	endtask
	// watchdog: the whole sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		tally_and_finish();
	end
	// reset is held two cycles; the synchroniser clears on the first edge
	initial begin
		reset = 1'b1;
		service_req = 1'b0;
		cfg = {5'h1E, 3'b000};
		tx_src = {8'h00, 1'b0};
		tx_valid = 1'b0;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		repeat (3) @(negedge mclk);
		cmp_state(5'b00000);
		cmp_bit("eoi_oe_n", 1'b1, eoi_oe_n);
		t_addr(5'h00);
		t_addr(5'h1E);
		t_remote();
		t_clear();
		t_data();
		t_talk();
		t_poll();
		tally_and_finish();
	end
endmodule
`default_nettype wire
